/* File: src/crystal_pull_trim_map.vh */
`ifndef CRYSTAL_PULL_TRIM_MAP_VH
`define CRYSTAL_PULL_TRIM_MAP_VH
// fixed 7-bit bus address
`define CRYSTAL_PULL_TRIM_BUS_ADDR 7'h69
// register address of the pull-trim register
`define CRYSTAL_PULL_TRIM_TRIM_ADDR 8'h13
// number of registers in the small bank
`define CRYSTAL_PULL_TRIM_BANK_DEPTH 2
`define CRYSTAL_PULL_TRIM_BANK_AW 1
// reset value of the pull-trim register (mid scale)
`define CRYSTAL_PULL_TRIM_TRIM_RESET 8'h80
`endif

/* File: src/crystal_pull_trim_trim_reg.v */
`timescale 1ns/1ps
module crystal_pull_trim_trim_reg #(
  parameter W = 8,
  parameter RESET_VAL = 8'h80
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // write side
  input wire wr_en,
  input wire [W-1:0] wr_data,
  // stored value
  output reg [W-1:0] value_r
);
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      value_r <= RESET_VAL;
    end else if (wr_en) begin
      value_r <= wr_data;
    end
  end
endmodule

/* File: src/crystal_pull_trim_serial_write_port.v */
`timescale 1ns/1ps
`include "crystal_pull_trim_map.vh"
module crystal_pull_trim_serial_write_port (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // two-wire link
  input wire serial_clock_in,
  input wire serial_data_line_in,
  output reg serial_data_line_out_r,
  output reg serial_data_line_oe_n_r,
  // crystal load trim
  output reg [7:0] crystal_pull_trim_r
);
  // frame states
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADR = 3'h1;
  localparam ST_REGADR = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_IGNORE = 3'h5;
  // synchronised pins: bit 0 is the link clock, bit 1 the data line
  localparam NUM_PINS = 2;
  localparam PIN_CLK = 0;
  localparam PIN_DAT = 1;

  wire [NUM_PINS-1:0] pin_raw;
  wire [NUM_PINS-1:0] pin_sync;
  wire [NUM_PINS-1:0] pin_prev;
  reg [2:0] state_r;
  reg [2:0] after_ack_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] reg_addr_r;
  reg ack_drive_r;
  reg wr_en_r;
  reg [7:0] wr_data_r;
  reg oe_n_nxt;
  wire [7:0] trim_value;

  assign pin_raw[PIN_CLK] = serial_clock_in;
  assign pin_raw[PIN_DAT] = serial_data_line_in;

  wire scl = pin_sync[PIN_CLK];
  wire sda = pin_sync[PIN_DAT];
  wire scl_d = pin_prev[PIN_CLK];
  wire sda_d = pin_prev[PIN_DAT];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // conditions only count while clock stays high
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;
  wire byte_done = scl_fall & (bit_cnt_r == 4'h8);
  wire [7:0] byte_in = {shift_r[6:0], sda};

  // register address decode, used for the address byte and every data byte
  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `CRYSTAL_PULL_TRIM_TRIM_ADDR);
    end
  endfunction

  // first byte after a start: our address with the direction bit low
  function dev_addr_ok;
    input [7:0] b;
    begin
      dev_addr_ok = (b[7:1] == `CRYSTAL_PULL_TRIM_BUS_ADDR) && !b[0];
    end
  endfunction

  // a pin edge reaches the state machine two clocks late and the ack leaves one
  // clock later still, so each link clock phase must last at least three clocks
  // two-flop synchroniser per pin; the previous value feeds the edge detectors
  // and starts at the idle level high, so reset makes no false edge
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
      reg [1:0] sync_r;
      reg prev_r;
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          sync_r <= 2'h3;
          prev_r <= 1'h1;
        end else begin
          sync_r <= {sync_r[0], pin_raw[gi]};
          prev_r <= sync_r[1];
        end
      end
      assign pin_sync[gi] = sync_r[1];
      assign pin_prev[gi] = prev_r;
    end
  endgenerate

  // frame state machine; a start or stop overrides whatever is in progress
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      reg_addr_r <= 8'h00;
      ack_drive_r <= 1'h0;
      wr_en_r <= 1'h0;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= 1'h0;
      if (start_det) begin
        // a start restarts the frame from any state
        state_r <= ST_DEVADR;
        bit_cnt_r <= 4'h0;
        ack_drive_r <= 1'h0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        ack_drive_r <= 1'h0;
      end else begin
        case (state_r)
          ST_DEVADR, ST_REGADR, ST_DATA: begin
            // sample on rising clock edge, data stable while high
            if (scl_rise) begin
              shift_r <= byte_in;
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (byte_done) begin
              bit_cnt_r <= 4'h0;
              state_r <= ST_ACK;
              ack_drive_r <= 1'h1;
              case (state_r)
                ST_DEVADR: begin
                  after_ack_r <= ST_REGADR;
                  if (!dev_addr_ok(shift_r)) begin
                    state_r <= ST_IGNORE;
                    ack_drive_r <= 1'h0;
                  end
                end
                ST_REGADR: begin
                  reg_addr_r <= shift_r;
                  after_ack_r <= ST_DATA;
                  if (!addr_known(shift_r)) begin
                    state_r <= ST_IGNORE;
                    ack_drive_r <= 1'h0;
                  end
                end
                default: begin
                  // data byte: stored only at a known address, always acked
                  after_ack_r <= ST_DATA;
                  wr_en_r <= addr_known(reg_addr_r);
                  wr_data_r <= shift_r;
                  reg_addr_r <= reg_addr_r + 8'h01;
                end
              endcase
            end
          end
          ST_ACK: begin
            // hold ack low for the whole ninth clock
            if (scl_fall) begin
              ack_drive_r <= 1'h0;
              state_r <= after_ack_r;
            end
          end
          ST_IGNORE: begin
            // deaf until the next start or stop
            state_r <= ST_IGNORE;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // the line is pulled only inside an ack phase, and a start or stop
  // lets it go in the same clock
  always @* begin
    oe_n_nxt = 1'h1;
    if (ack_drive_r && (state_r == ST_ACK)) begin
      oe_n_nxt = 1'h0;
    end
    if (start_det || stop_det) begin
      oe_n_nxt = 1'h1;
    end
  end

  // every output leaves a flop; the drive value is high in reset and low after it
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serial_data_line_out_r <= 1'h1;
      serial_data_line_oe_n_r <= 1'h1;
      crystal_pull_trim_r <= `CRYSTAL_PULL_TRIM_TRIM_RESET;
    end else begin
      serial_data_line_out_r <= 1'h0;
      serial_data_line_oe_n_r <= oe_n_nxt;
      crystal_pull_trim_r <= trim_value;
    end
  end

  crystal_pull_trim_trim_reg #(
    .W(8),
    .RESET_VAL(`CRYSTAL_PULL_TRIM_TRIM_RESET)
  ) u_trim (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(wr_en_r),
    .wr_data(wr_data_r),
    .value_r(trim_value)
  );
endmodule

/* File: bench/crystal_pull_trim_chk.sv */
`timescale 1ns/1ps
module crystal_pull_trim_chk (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // link
  input wire serial_clock_in,
  input wire serial_data_line_in,
  input wire serial_data_line_out_r,
  input wire serial_data_line_oe_n_r,
  // trim
  input wire [7:0] crystal_pull_trim_r
);
  wire oe = serial_data_line_oe_n_r;
  wire scl = serial_clock_in;
  wire sda = serial_data_line_in;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_drv; !oe |-> !serial_data_line_out_r; endproperty
  a_drv: assert property (p_drv) else $error("ack not low");
  property p_on; $fell(oe) |-> !scl; endproperty
  a_on: assert property (p_on) else $error("ack starts in high");
  property p_off; $rose(oe) |-> !scl; endproperty
  a_off: assert property (p_off) else $error("ack ends in high");
  property p_len; $fell(oe) |-> !oe [*6]; endproperty
  a_len: assert property (p_len) else $error("ack short");
  property p_end; $fell(oe) |-> ##[6:10] oe; endproperty
  a_end: assert property (p_end) else $error("ack long");
  property p_sta; scl && $fell(sda) |-> oe [*8]; endproperty
  a_sta: assert property (p_sta) else $error("drive after start");
  property p_sto; scl && $rose(sda) |=> oe [*8]; endproperty
  a_sto: assert property (p_sto) else $error("drive after stop");
  property p_wr; $changed(crystal_pull_trim_r) |-> ##[0:4] !oe; endproperty
  a_wr: assert property (p_wr) else $error("write without ack");
  c_ack: cover property ($fell(oe));
  c_wr: cover property ($changed(crystal_pull_trim_r));
  c_sto: cover property (scl && $rose(sda));
endmodule
bind crystal_pull_trim_serial_write_port crystal_pull_trim_chk u_chk (.mclk(mclk), .rstn(rstn),
  .serial_clock_in(serial_clock_in), .serial_data_line_in(serial_data_line_in),
  .serial_data_line_out_r(serial_data_line_out_r),
  .serial_data_line_oe_n_r(serial_data_line_oe_n_r),
  .crystal_pull_trim_r(crystal_pull_trim_r));

/* File: bench/crystal_pull_trim_master.sv */
`timescale 1ns/1ps
module crystal_pull_trim_master (
  // link
  input wire mclk,
  input wire sda,
  output logic scl = 1'h1,
  output logic sda_m = 1'h1
);
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic bit1(input logic b, output logic s);
    w(1);
    sda_m = b;
    w(4);
    scl = 1'h1;
    w(2);
    s = sda;
    w(1);
    scl = 1'h0;
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(d[i], s);
    bit1(1'h1, s);
    ack = !s;
  endtask
  // works from idle and as a repeated start after an ack
  task automatic start;
    w(1);
    sda_m = 1'h1;
    w(4);
    scl = 1'h1;
    w(24);
    sda_m = 1'h0;
    w(24);
    scl = 1'h0;
  endtask
  task automatic stop;
    w(1);
    sda_m = 1'h0;
    w(4);
    scl = 1'h1;
    w(24);
    sda_m = 1'h1;
    w(52);
  endtask
endmodule

/* File: bench/crystal_pull_trim_serial_write_port_tb_top.sv */
`timescale 1ns/1ps
module crystal_pull_trim_serial_write_port_tb_top;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  wire scl, sda_m, out_r, oe_n;
  wire [7:0] trim;
  wire sda = sda_m & (oe_n | out_r);
  int num_errors = 0;
  int n_compared = 0;
  crystal_pull_trim_master u_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
  crystal_pull_trim_serial_write_port u_dut (.mclk(mclk), .rstn(rstn), .serial_clock_in(scl),
    .serial_data_line_in(sda), .serial_data_line_out_r(out_r),
    .serial_data_line_oe_n_r(oe_n), .crystal_pull_trim_r(trim));
  initial forever #12.5 mclk = ~mclk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_ack(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // start, address byte, register, two data bytes; acks collected first byte first
  task automatic frame(input logic [7:0] a, r, d0, d1, output logic [3:0] k);
    logic [7:0] b [4];
    logic g;
    b = '{a, r, d0, d1};
    k = 4'h0;
    u_mst.start();
    for (int i = 0; i < 4; i++) begin
      u_mst.wb(b[i], g);
      k = {k[2:0], g};
    end
  endtask
  // one whole transfer ended by a stop; expected acks and trim
  task automatic xfer(input logic [7:0] a, r, d0, d1, input logic [3:0] ea,
                      input logic [7:0] et);
    logic [3:0] k;
    frame(a, r, d0, d1, k);
    u_mst.stop();
    cmp_ack(k, ea);
    cmp(trim, et);
  endtask
  initial begin
    logic [3:0] k;
    repeat (3) @(posedge mclk);
    #1 rstn = 1'h1;
    u_mst.w(3);
    cmp(trim, 8'h80);
    xfer(8'hD2, 8'h13, 8'hFF, 8'h00, 4'hF, 8'hFF);
    xfer(8'hD2, 8'h13, 8'h00, 8'h5A, 4'hF, 8'h00);
    xfer(8'hD3, 8'h13, 8'h55, 8'h55, 4'h0, 8'h00);
    xfer(8'hD0, 8'h13, 8'h55, 8'h55, 4'h0, 8'h00);
    xfer(8'hD2, 8'h12, 8'h55, 8'h55, 4'h8, 8'h00);
    // a repeated start without a stop opens a fresh frame
    frame(8'hD2, 8'h13, 8'h11, 8'h22, k);
    cmp_ack(k, 4'hF);
    cmp(trim, 8'h11);
    xfer(8'hD2, 8'h13, 8'h66, 8'h77, 4'hF, 8'h66);
    xfer(8'hD2, 8'h13, 8'hA5, 8'h3C, 4'hF, 8'hA5);
    stop_test();
  end
  initial begin
    #150000;
    num_errors++;
    stop_test();
  end
endmodule
